/* File: shared/dac_port_pkg.sv */
// Constants and types for the host controller of the dual-channel parallel
// converter port. Assumes a 250 MHz system clock.
package dac_port_pkg;
   // ----------------------------------------------------------------
   // Bus geometry
   // ----------------------------------------------------------------
   localparam int DATA_W = 12;
   localparam logic CHAN_A = 1'b0;
   localparam logic CHAN_B = 1'b1;
   localparam logic RW_WRITE = 1'b0;
   localparam logic RW_READ = 1'b1;

   // ----------------------------------------------------------------
   // Timing in ns and derived cycle counts
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 4000;
   localparam int T_SETUP_NS = 10;
   localparam int T_CS_LOW_NS = 10;
   localparam int T_CS_HIGH_NS = 7;
   localparam int T_RW_TO_CS_NS = 5;
   localparam int T_ACCESS_MAX_NS = 25;
   localparam int T_RELINQUISH_MAX_NS = 10;

   // Least times round up, never less than one cycle.
   function automatic int cyc_up(input int ns);
      int c;
      c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
      return (c < 1) ? 1 : c;
   endfunction

   localparam int SETUP_CYC = cyc_up(T_SETUP_NS);
   localparam int CS_LOW_CYC = cyc_up(T_CS_LOW_NS);
   localparam int ACCESS_CYC = cyc_up(T_ACCESS_MAX_NS);
   localparam int CS_HIGH_CYC = cyc_up(T_CS_HIGH_NS);
   localparam int RW_TO_CS_CYC = cyc_up(T_RW_TO_CS_NS);
   localparam int RELINQUISH_CYC = cyc_up(T_RELINQUISH_MAX_NS);
   // Pin data reaches the logic two edges late through the synchroniser.
   localparam int SYNC_CYC = 2;

   localparam int CNT_W = 4;
   localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
   localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
   localparam logic [DATA_W-1:0] DATA_ZERO = 12'h000;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SETUP,
      ST_STROBE,
      ST_HOLD,
      ST_GAP
   } phase_t;
endpackage

/* File: design/dac_sync2.sv */
// Two-flop synchroniser for a vector arriving from the device pins.
// Assumes the receiving logic runs on clk.
`timescale 1ns/1ps
`default_nettype none
module dac_sync2 #(parameter int W = 12)
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] stage1_r;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         stage1_r <= '0;
         dout <= '0;
      end
      else
      begin
         stage1_r <= din;
         dout <= stage1_r;
      end
   end
endmodule
`default_nettype wire

/* File: design/dac_host_port.sv */
// Host-side controller driving the parallel write/readback pins of a
// dual-channel converter. Assumes the device is the only other driver of
// the data lines and that the user side runs on clk.
`timescale 1ns/1ps
`default_nettype none
module dac_host_port
   import dac_port_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic reqValid,
   output logic reqReady,
   input wire logic reqRead,
   input wire logic reqChan,
   input wire logic [DATA_W-1:0] reqData,
   output logic rspValid,
   output logic [DATA_W-1:0] rspData,
   output logic chanSel,
   output logic chipSelN,
   output logic readNotWrite,
   input wire logic [DATA_W-1:0] dataIn,
   output logic [DATA_W-1:0] dataOut,
   output logic dataOe
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   phase_t phase_r, phase_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic read_r;
   logic chan_r;
   logic [DATA_W-1:0] wdata_r;
   logic rspValid_r;
   logic [DATA_W-1:0] rspData_r;
   logic [DATA_W-1:0] dataSync;
   logic chipSelN_r;
   logic readNotWrite_r;
   logic dataOe_r;

   // Pin data crosses from the device, so it is synchronised; the extra
   // latency is covered by stretching the strobe in read accesses.
   dac_sync2 #(.W(DATA_W)) u_sync
   (
      .clk(clk),
      .rstn(rstn),
      .din(dataIn),
      .dout(dataSync)
   );

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   wire cntDone = (cnt_r == CNT_ZERO);
   wire take = reqValid && (phase_r == ST_IDLE);
   wire strobeEnd = (phase_r == ST_STROBE) && cntDone;
   wire sampleNow = strobeEnd && read_r;
   // Read strobes last the access time plus the synchroniser delay.
   wire [CNT_W-1:0] strobeLen = read_r
      ? CNT_W'(ACCESS_CYC + SYNC_CYC - 1) : CNT_W'(CS_LOW_CYC - 1);
   wire [CNT_W-1:0] gapLen = read_r
      ? CNT_W'(RELINQUISH_CYC + RW_TO_CS_CYC - 1)
      : CNT_W'(CS_HIGH_CYC - 1);

   assign reqReady = (phase_r == ST_IDLE);
   assign rspValid = rspValid_r;
   assign rspData = rspData_r;
   assign chanSel = chan_r;
   assign chipSelN = chipSelN_r;
   assign readNotWrite = readNotWrite_r;
   assign dataOut = wdata_r;
   assign dataOe = dataOe_r;
   // The pin controls are decoded from the next state and registered, so a
   // state change of several bits can never glitch a strobe at the device.
   wire readNxt = take ? reqRead : read_r;
   // Chip select goes low only in the strobe phase, after setup.
   wire csNxt = (phase_nxt != ST_STROBE);
   // Read/write stays at the write level only while a write is in flight;
   // idle it rests high so that no latch goes transparent by accident.
   wire rwNxt = (phase_nxt == ST_IDLE || readNxt)
      ? RW_READ : RW_WRITE;
   // The word stays on the lines one cycle past the rise of chip select,
   // which gives the device a full cycle of data hold.
   wire oeNxt = !readNxt && (phase_nxt == ST_SETUP
      || phase_nxt == ST_STROBE || phase_nxt == ST_HOLD);

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_comb
   begin
      phase_nxt = phase_r;
      cnt_nxt = cnt_r;
      case (phase_r)
         ST_IDLE:
         begin
            if (reqValid)
            begin
               phase_nxt = ST_SETUP;
               cnt_nxt = CNT_W'(SETUP_CYC - 1);
            end
         end
         ST_SETUP:
         begin
            if (cntDone)
            begin
               phase_nxt = ST_STROBE;
               cnt_nxt = strobeLen;
            end
            else
               cnt_nxt = cnt_r - CNT_ONE;
         end
         ST_STROBE:
         begin
            if (cntDone)
            begin
               phase_nxt = ST_HOLD;
               cnt_nxt = CNT_ZERO;
            end
            else
               cnt_nxt = cnt_r - CNT_ONE;
         end
         ST_HOLD:
         begin
            phase_nxt = ST_GAP;
            cnt_nxt = gapLen;
         end
         ST_GAP:
         begin
            if (cntDone)
               phase_nxt = ST_IDLE;
            else
               cnt_nxt = cnt_r - CNT_ONE;
         end
         default:
         begin
            phase_nxt = ST_IDLE;
            cnt_nxt = CNT_ZERO;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         phase_r <= ST_IDLE;
         cnt_r <= CNT_ZERO;
      end
      else
      begin
         phase_r <= phase_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         chipSelN_r <= 1'b1;
         readNotWrite_r <= RW_READ;
         dataOe_r <= 1'b0;
      end
      else
      begin
         chipSelN_r <= csNxt;
         readNotWrite_r <= rwNxt;
         dataOe_r <= oeNxt;
      end
   end

   // Request fields are held for the whole access.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         read_r <= RW_READ;
         chan_r <= CHAN_A;
         wdata_r <= DATA_ZERO;
      end
      else if (take)
      begin
         read_r <= reqRead;
         chan_r <= reqChan;
         wdata_r <= reqData;
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rspValid_r <= 1'b0;
         rspData_r <= DATA_ZERO;
      end
      else
      begin
         rspValid_r <= sampleNow;
         if (sampleNow)
            rspData_r <= dataSync;
      end
   end
endmodule
`default_nettype wire

/* File: test/dac_host_port_checker.sv */
// Checker for the host port pins, bound to every instance of the port.
// Assumes only the top module's ports and the clk domain.
`timescale 1ns/1ps
`default_nettype none
module dac_host_port_checker
   import dac_port_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic reqValid,
   input wire logic reqReady,
   input wire logic reqRead,
   input wire logic reqChan,
   input wire logic [DATA_W-1:0] reqData,
   input wire logic rspValid,
   input wire logic [DATA_W-1:0] rspData,
   input wire logic chanSel,
   input wire logic chipSelN,
   input wire logic readNotWrite,
   input wire logic [DATA_W-1:0] dataIn,
   input wire logic [DATA_W-1:0] dataOut,
   input wire logic dataOe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   AST_CHAN_HOLD: assert property (!chipSelN |-> $stable(chanSel))
      else $error("channel select moved during an access");
   AST_RW_FIRST: assert property (
      $fell(chipSelN) |-> $stable(readNotWrite))
      else $error("read/write changed as chip select fell");
   AST_WR_DRIVE: assert property (
      !chipSelN && !readNotWrite |-> dataOe && $stable(dataOut))
      else $error("write word not held on the lines");
   AST_WR_HOLD: assert property (
      $rose(chipSelN) && !readNotWrite |-> dataOe && $stable(dataOut))
      else $error("write word released as chip select rose");
   AST_RD_FREE: assert property (readNotWrite |-> !dataOe)
      else $error("host drives the lines while reading");
   AST_RD_ANSWER: assert property (
      $rose(chipSelN) && readNotWrite |-> rspValid ##1 !rspValid)
      else $error("read answer not a single pulse at strobe end");
endmodule
bind dac_host_port dac_host_port_checker u_chk (.*);
`default_nettype wire

/* File: test/dac_dev_model.sv */
// Behavioural model of the dual-channel converter's parallel port.
// Assumes the bench resolves the data lines and feeds them back on busIn.
`timescale 1ns/1ps
`default_nettype none
module dac_dev_model
   import dac_port_pkg::*;
#(parameter int ACCESS_NS = 25)
(
   input wire logic chanSel,
   input wire logic chipSelN,
   input wire logic readNotWrite,
   input wire logic [DATA_W-1:0] busIn,
   output logic [DATA_W-1:0] devOut
);
   logic [DATA_W-1:0] regA = DATA_ZERO;
   logic [DATA_W-1:0] regB = DATA_ZERO;
   logic [DATA_W-1:0] selReg;
   // Transparent while selected for write, so the last word stays on release.
   always @*
      if (!chipSelN && !readNotWrite)
         if (chanSel)
            regB = busIn;
         else
            regA = busIn;
   assign selReg = chanSel ? regB : regA;
   // Answers at the slowest access time; released lines show the inverse.
   assign #(ACCESS_NS) devOut = (!chipSelN && readNotWrite)
      ? selReg : ~selReg;
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
// Self-checking bench for the host port against the converter model.
// Assumes the design package and a 250 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import dac_port_pkg::*;
;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic reqValid = 1'b0;
   logic reqRead = 1'b0;
   logic reqChan = 1'b0;
   logic [DATA_W-1:0] reqData = DATA_ZERO;
   logic reqReady, rspValid, chanSel, chipSelN, readNotWrite, dataOe;
   logic [DATA_W-1:0] rspData, dataOut, devOut, bus;
   int errors = 0;
   int tests_run = 0;
   always #2 clk = ~clk;
   assign bus = dataOe ? dataOut : devOut;
   dac_host_port u_dut (.clk(clk), .rstn(rstn), .reqValid(reqValid),
      .reqReady(reqReady), .reqRead(reqRead), .reqChan(reqChan),
      .reqData(reqData), .rspValid(rspValid), .rspData(rspData),
      .chanSel(chanSel), .chipSelN(chipSelN), .readNotWrite(readNotWrite),
      .dataIn(bus), .dataOut(dataOut), .dataOe(dataOe));
   dac_dev_model u_dev (.chanSel(chanSel), .chipSelN(chipSelN),
      .readNotWrite(readNotWrite), .busIn(bus), .devOut(devOut));
   task automatic check(input logic [DATA_W-1:0] got,
      input logic [DATA_W-1:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         errors++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic stop_test;
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Present one request, hold it to the taking edge, then wait for idle or for the read answer.
   task automatic access(input logic rd, input logic ch,
      input logic [DATA_W-1:0] d);
      int n;
      n = 0;
      while (reqReady !== 1'b1 && n < 40)
      begin
         @(negedge clk);
         n++;
      end
      // A wait that runs out counts as a mismatch.
      check(n < 40, 1'b1);
      @(posedge clk);
      reqValid <= 1'b1;
      reqRead <= rd;
      reqChan <= ch;
      reqData <= d;
      @(posedge clk);
      reqValid <= 1'b0;
      @(negedge clk);
      check(reqReady, 1'b0);
      check(chanSel, ch);
      check(readNotWrite, rd);
      check(dataOe, !rd);
      while (reqReady !== 1'b1 && rspValid !== 1'b1 && n < 80)
      begin
         @(negedge clk);
         n++;
      end
      check(n < 80, 1'b1);
   endtask
   // Reset lands in the middle of a write strobe; the pins must fall back
   // to idle and the next accesses must work from a clean start.
   task automatic t_reset_mid;
      repeat (8) @(posedge clk);
      reqValid <= 1'b1;
      reqRead <= RW_WRITE;
      reqChan <= CHAN_A;
      reqData <= 12'h3c6;
      @(posedge clk);
      reqValid <= 1'b0;
      repeat (4) @(posedge clk);
      rstn <= 1'b0;
      @(negedge clk);
      check(chipSelN, 1'b1);
      check(dataOe, 1'b0);
      check(reqReady, 1'b1);
      check(rspValid, 1'b0);
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      access(RW_WRITE, CHAN_A, 12'h3c6);
      access(RW_READ, CHAN_A, DATA_ZERO);
      check(rspData, 12'h3c6);
   endtask
   task automatic t_idle_pins;
      check(chipSelN, 1'b1);
      check(dataOe, 1'b0);
      check(readNotWrite, 1'b1);
   endtask
   task automatic t_write_both;
      access(RW_WRITE, CHAN_A, 12'h5a3);
      access(RW_WRITE, CHAN_B, 12'ha5c);
      check(u_dev.regA, 12'h5a3);
      check(u_dev.regB, 12'ha5c);
   endtask
   task automatic t_read_both;
      access(RW_READ, CHAN_A, DATA_ZERO);
      check(rspData, 12'h5a3);
      access(RW_READ, CHAN_B, DATA_ZERO);
      check(rspData, 12'ha5c);
   endtask
   task automatic t_b2b_edges;
      access(RW_WRITE, CHAN_B, 12'hfff);
      access(RW_READ, CHAN_B, DATA_ZERO);
      check(rspData, 12'hfff);
      access(RW_WRITE, CHAN_A, 12'h000);
      access(RW_READ, CHAN_A, DATA_ZERO);
      check(rspData, 12'h000);
      check(u_dev.regB, 12'hfff);
   endtask
   initial
   begin
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      @(negedge clk);
      t_idle_pins();
      t_write_both();
      t_read_both();
      t_b2b_edges();
      t_reset_mid();
      t_idle_pins();
      stop_test();
   end
   // A hang is cut short well past the fewer than two hundred cycles the run needs.
   initial
   begin
      #20000;
      errors++;
      stop_test();
   end
endmodule
`default_nettype wire
